// ==== logic/hpm_defs.vh ====
// Contract
// RULE1: Watch each port's overcurrent input independently.
// RULE2: Overcurrent sets port status and change bits.
// RULE3: Overcurrent cuts power, blinks indicator about 1 s.
// RULE4: Port power only on host set-power request.
// RULE5: Power off at reset, overcurrent, clear request.
// RULE6: Blink until port switched off or hub clear.
// RULE7: Indicators inactive after power-up or reset.
// RULE8: Indicator active once port is enabled.
// RULE9: Any port disable makes indicator inactive.
// RULE10: No port power before hub is configured.
// RULE11: Two endpoints and a controller status register.
// RULE12: Controller status register clears to zero.
// RULE13: Status bits: configured, wakeup, ep0, ep1 stall.
// RULE14: Change bitmap sampled at EOF2, hub bit 0.
// RULE15: Endpoint 1 NAKs empty bitmap, else sends byte.
// RULE16: Shared free-running divider makes blink period.
// RULE17: Two flip-flop sync on each overcurrent input.
`ifndef HPM_DEFS_VH
`define HPM_DEFS_VH

// Register byte offsets
`define HPM_A_CTRL 8'h00
`define HPM_A_CMD 8'h04
`define HPM_A_PSTAT 8'h08
`define HPM_A_CHG 8'h0C
`define HPM_A_ISTAT 8'h10
`define HPM_A_IMASK 8'h14

// Controller status bits
`define HPM_CS_CFG 0
`define HPM_CS_WAKE 1
`define HPM_CS_EP0STL 2
`define HPM_CS_EP1STL 3
`define HPM_CS_W 4
`define HPM_CS_RST 4'h0

// Command strobe fields, four port bits each; hub clear is a single bit
`define HPM_C_PWR_ON 0
`define HPM_C_PWR_OFF 4
`define HPM_C_EN_ON 8
`define HPM_C_EN_OFF 12
`define HPM_C_OCC_CLR 16
`define HPM_C_HUB_CLR 20

// Port status fields
`define HPM_S_PWR 0
`define HPM_S_EN 4
`define HPM_S_OC 8
`define HPM_S_OCC 12
`define HPM_S_BLK 16

// Interrupt status bits
`define HPM_I_OC 0
`define HPM_I_CHG 4
`define HPM_I_W 5

// Blink timing
`define HPM_BLINK_HALF_MS 25'h1F4
`define HPM_CLK_KHZ 25'hC350

// Bus responses
`define HPM_RESP_OK 2'h0
`define HPM_RESP_ERR 2'h2

`endif

// ==== logic/hpm_sync.v ====
`default_nettype none

module hpm_sync #(
  parameter W = 4,
  parameter [W-1:0] RST = {W{1'b1}}
) (
  // Clock and reset
  input wire sys_clk,
  input wire arst_n,
  // Data
  input wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= RST;
      s2_q <= RST;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;

endmodule // hpm_sync

`default_nettype wire

// ==== logic/hpm_port_power.v ====
`include "hpm_defs.vh"
`default_nettype none

module hpm_port_power #(
  parameter NP = 4,
  parameter CNT_W = 25,
  parameter [CNT_W-1:0] BLINK_HALF_CYC =
    `HPM_BLINK_HALF_MS * `HPM_CLK_KHZ
) (
  // Clock and reset
  input wire sys_clk,
  input wire arst_n,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Port pins
  input wire [NP-1:0] port_overcurrent_in_n,
  output wire [NP-1:0] port_power_ctl,
  output wire [NP-1:0] port_indicator_n,
  // Frame timing and hub-level change
  input wire eof2_pulse,
  input wire hub_change,
  // Interrupt endpoint
  input wire ep1_in_token,
  output wire ep1_nak,
  output wire ep1_send,
  output wire [7:0] ep1_data,
  // Interrupt
  output wire irq
);

  // Write mask from byte strobes
  function [31:0] strb_mask;
    input [3:0] strb;
    integer k;
    begin
      strb_mask = 32'h0000_0000;
      for (k = 0; k < 4; k = k + 1)
        strb_mask[k*8 +: 8] = {8{strb[k]}};
    end
  endfunction

  // Address decode shared by both channels
  function is_mapped;
    input [7:0] a;
    begin
      case (a)
        `HPM_A_CTRL, `HPM_A_CMD, `HPM_A_PSTAT,
        `HPM_A_CHG, `HPM_A_ISTAT, `HPM_A_IMASK: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // Bus slave state
  reg aw_hold_q;
  reg [7:0] awaddr_q;
  reg w_hold_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  reg [31:0] rd_mux;

  // Block state
  reg [`HPM_CS_W-1:0] ctrl_q;
  reg [NP-1:0] pwr_q;
  reg [NP-1:0] pwr_d;
  reg [NP-1:0] en_q;
  reg [NP-1:0] en_d;
  reg [NP-1:0] occ_q;
  reg [NP-1:0] occ_d;
  reg [NP-1:0] blink_q;
  reg [NP-1:0] blink_d;
  reg [NP-1:0] oc_prev_q;
  reg [NP-1:0] ind_n_q;
  reg [NP-1:0] ind_n_d;
  reg [7:0] chg_map_q;
  reg [`HPM_I_W-1:0] istat_q;
  reg [`HPM_I_W-1:0] imask_q;
  reg [CNT_W-1:0] blink_cnt_q;
  reg blink_ph_q;
  reg ep1_nak_q;
  reg ep1_send_q;
  reg [7:0] ep1_data_q;

  wire [NP-1:0] oc_sync_n;
  wire [NP-1:0] oc;
  wire [NP-1:0] oc_rise;
  wire aw_hs;
  wire w_hs;
  wire ar_hs;
  wire wr_go;
  wire [31:0] wr_data;
  wire [31:0] cmd;
  wire wr_ctrl;
  wire wr_istat;
  wire wr_imask;
  wire cfg;
  wire hub_clr;
  wire [7:0] map_d;
  wire map_set;

  // Each pin sampled on its own, released high
  hpm_sync #(
    .W(NP),
    .RST({NP{1'b1}})
  ) u_oc_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .d(port_overcurrent_in_n),
    .q(oc_sync_n)
  ); // RULE17

  assign oc = ~oc_sync_n; // RULE1
  assign oc_rise = oc & ~oc_prev_q; // RULE1

  // Write channel: address and data latched in either order
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign wr_go = aw_hold_q && w_hold_q;
  assign wr_data = wdata_q & strb_mask(wstrb_q);
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      w_hold_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `HPM_RESP_OK;
    end else begin
      if (aw_hs) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(awaddr_q) ? `HPM_RESP_OK : `HPM_RESP_ERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Write decode; command register is strobe-only
  assign wr_ctrl = wr_go && (awaddr_q == `HPM_A_CTRL);
  assign wr_istat = wr_go && (awaddr_q == `HPM_A_ISTAT);
  assign wr_imask = wr_go && (awaddr_q == `HPM_A_IMASK);
  assign cmd = (wr_go && (awaddr_q == `HPM_A_CMD)) ? wr_data :
    32'h0000_0000;
  assign hub_clr = cmd[`HPM_C_HUB_CLR];
  assign cfg = ctrl_q[`HPM_CS_CFG];

  // Read channel
  assign s_axi_arready = !rvalid_q;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `HPM_A_CTRL: rd_mux[`HPM_CS_W-1:0] = ctrl_q; // RULE11 RULE13
      `HPM_A_PSTAT: begin
        rd_mux[`HPM_S_PWR +: NP] = pwr_q;
        rd_mux[`HPM_S_EN +: NP] = en_q;
        rd_mux[`HPM_S_OC +: NP] = oc; // RULE2
        rd_mux[`HPM_S_OCC +: NP] = occ_q; // RULE2
        rd_mux[`HPM_S_BLK +: NP] = blink_q;
      end
      `HPM_A_CHG: rd_mux[7:0] = chg_map_q;
      `HPM_A_ISTAT: rd_mux[`HPM_I_W-1:0] = istat_q;
      `HPM_A_IMASK: rd_mux[`HPM_I_W-1:0] = imask_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `HPM_RESP_OK;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= is_mapped(s_axi_araddr) ? `HPM_RESP_OK :
        `HPM_RESP_ERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Controller status register, all zero out of reset
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `HPM_CS_RST; // RULE12
    end else if (wr_ctrl) begin
      ctrl_q <= wr_data[`HPM_CS_W-1:0]; // RULE11 RULE13
    end
  end

  // Port power, enable and change next-state
  always @* begin
    // Set request refused while unconfigured or still overloaded
    pwr_d = (pwr_q | (cmd[`HPM_C_PWR_ON +: NP] & {NP{cfg}} & ~oc))
      & ~cmd[`HPM_C_PWR_OFF +: NP] & ~oc & {NP{cfg}}; // RULE4 RULE5 RULE10
    // Port drops out of enabled with its power
    en_d = (en_q | (cmd[`HPM_C_EN_ON +: NP] & pwr_q))
      & ~cmd[`HPM_C_EN_OFF +: NP] & pwr_d; // RULE9
    // New overcurrent wins over a same-cycle clear
    occ_d = (occ_q & ~cmd[`HPM_C_OCC_CLR +: NP]) | oc_rise; // RULE2
    blink_d = (blink_q & ~cmd[`HPM_C_PWR_OFF +: NP] & ~{NP{hub_clr}})
      | oc_rise; // RULE3 RULE6
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_q <= {NP{1'b0}}; // RULE5
      en_q <= {NP{1'b0}};
      occ_q <= {NP{1'b0}};
      blink_q <= {NP{1'b0}};
      oc_prev_q <= {NP{1'b0}};
    end else begin
      pwr_q <= pwr_d; // RULE3 RULE5
      en_q <= en_d;
      occ_q <= occ_d;
      blink_q <= blink_d;
      oc_prev_q <= oc;
    end
  end

  assign port_power_ctl = pwr_q;

  // Shared half-period divider; all ports blink in phase
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      blink_cnt_q <= {CNT_W{1'b0}};
      blink_ph_q <= 1'b0;
    end else if (blink_cnt_q == BLINK_HALF_CYC - 1'b1) begin
      blink_cnt_q <= {CNT_W{1'b0}}; // RULE16
      blink_ph_q <= ~blink_ph_q; // RULE3
    end else begin
      blink_cnt_q <= blink_cnt_q + 1'b1; // RULE16
    end
  end

  // Indicators: blink has priority, else lit while enabled
  always @* begin
    ind_n_d = ~en_q; // RULE8 RULE9
    ind_n_d = (blink_q & {NP{blink_ph_q}}) |
      (~blink_q & ind_n_d); // RULE3 RULE6
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ind_n_q <= {NP{1'b1}}; // RULE7
    end else begin
      ind_n_q <= ind_n_d;
    end
  end

  assign port_indicator_n = ind_n_q;

  // Change bitmap, hub in bit 0, silent until configured
  assign map_d = cfg ? {{(7-NP){1'b0}}, occ_q, hub_change} : 8'h00;
  assign map_set = eof2_pulse && (map_d != 8'h00);

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      chg_map_q <= 8'h00;
    end else if (eof2_pulse) begin
      chg_map_q <= map_d; // RULE14
    end
  end

  // Interrupt endpoint answer, one cycle after the token
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ep1_nak_q <= 1'b0;
      ep1_send_q <= 1'b0;
      ep1_data_q <= 8'h00;
    end else begin
      ep1_nak_q <= ep1_in_token && (chg_map_q == 8'h00); // RULE15
      ep1_send_q <= ep1_in_token && (chg_map_q != 8'h00); // RULE15
      if (ep1_in_token) begin
        ep1_data_q <= chg_map_q; // RULE15
      end
    end
  end

  assign ep1_nak = ep1_nak_q;
  assign ep1_send = ep1_send_q;
  assign ep1_data = ep1_data_q;

  // Sticky events, write one to clear; a new event wins
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      istat_q <= {`HPM_I_W{1'b0}};
      imask_q <= {`HPM_I_W{1'b0}};
    end else begin
      istat_q[`HPM_I_OC +: NP] <= (istat_q[`HPM_I_OC +: NP] &
        ~({NP{wr_istat}} & wr_data[`HPM_I_OC +: NP])) | oc_rise;
      istat_q[`HPM_I_CHG] <= (istat_q[`HPM_I_CHG] &
        ~(wr_istat & wr_data[`HPM_I_CHG])) | map_set;
      if (wr_imask) begin
        imask_q <= wr_data[`HPM_I_W-1:0];
      end
    end
  end

  assign irq = |(istat_q & imask_q);

endmodule // hpm_port_power

`default_nettype wire

// ==== bench/hpm_port_power_properties.sv ====
`default_nettype none
module hpm_chk #(
  parameter NP = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Bus handshakes
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port pins and endpoint
  input wire logic [NP-1:0] port_overcurrent_in_n,
  input wire logic [NP-1:0] port_power_ctl,
  input wire logic [NP-1:0] port_indicator_n,
  input wire logic ep1_in_token,
  input wire logic ep1_nak,
  input wire logic ep1_send
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [NP-1:0] p1_q, p2_q, ocl;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Low for three samples means both sync stages have seen it
  assign ocl = ~port_overcurrent_in_n & ~p1_q & ~p2_q;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      p1_q <= '1;
      p2_q <= '1;
    end else begin
      p1_q <= port_overcurrent_in_n;
      p2_q <= p1_q;
    end
  end
  sequence s_token;
    ep1_in_token ##1 1'b1;
  endsequence
  a_oc_cuts_power: assert property (($past(ocl) & port_power_ctl) == '0)
    else $error("power on a faulted port");
  a_power_by_write: assert property (|(port_power_ctl & ~$past(port_power_ctl))
    |-> (s_axi_bvalid || $past(s_axi_bvalid)))
    else $error("power rose without a write");
  a_reset_dark: assert property (!$past(arst_n) |-> port_indicator_n == '1)
    else $error("indicator lit after reset");
  a_reset_unpowered: assert property (!$past(arst_n) |-> port_power_ctl == '0)
    else $error("power on after reset");
  a_ep1_answer: assert property (s_token |-> ep1_nak != ep1_send)
    else $error("token without exactly one answer");
  a_ep1_cause: assert property (ep1_nak || ep1_send |-> $past(ep1_in_token))
    else $error("answer without token");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped");
endmodule // hpm_chk
bind hpm_port_power hpm_chk #(.NP(NP)) hpm_chk_inst (.sys_clk, .arst_n,
  .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready,
  .port_overcurrent_in_n, .port_power_ctl, .port_indicator_n,
  .ep1_in_token, .ep1_nak, .ep1_send);
`default_nettype wire

// ==== bench/hpm_switch_model.sv ====
`default_nettype none
module hpm_switch_model #(
  parameter NP = 4
) (
  // Clock
  input wire logic sys_clk,
  // Switch control and fault injection
  input wire logic [NP-1:0] port_power_ctl,
  input wire logic [NP-1:0] fault,
  // Flag pins, pulled up when quiet
  output logic [NP-1:0] port_overcurrent_in_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [NP-1:0] trip_q;
  // Flag persists with the fault even once power is cut
  always @(posedge sys_clk) trip_q <= fault & (trip_q | port_power_ctl);
  assign port_overcurrent_in_n = ~(fault & (trip_q | port_power_ctl));
endmodule // hpm_switch_model
`default_nettype wire

// ==== bench/tb.sv ====
`include "hpm_defs.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, arst_n, awv, wv, brd, arv, rrd, eof2, hubc, tok;
  logic awr, wr_r, bv, arr, rv, nak, snd, irq;
  logic [7:0] awa, ara, ep_d;
  logic [31:0] wd, rdat;
  logic [3:0] fault, ocn, pwr, ind;
  logic [1:0] br, rr;
  int err_total = 0, num_checks = 0, cyc = 0;
  hpm_port_power #(.BLINK_HALF_CYC(25'd8)) hpm_port_power_inst (
    .sys_clk, .arst_n, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd),
    .port_overcurrent_in_n(ocn), .port_power_ctl(pwr),
    .port_indicator_n(ind), .eof2_pulse(eof2), .hub_change(hubc),
    .ep1_in_token(tok), .ep1_nak(nak), .ep1_send(snd), .ep1_data(ep_d),
    .irq);
  hpm_switch_model hpm_switch_model_inst (.sys_clk, .port_power_ctl(pwr),
    .fault, .port_overcurrent_in_n(ocn));
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] e);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    brd <= 1;
    do begin
      @(posedge sys_clk);
      if (awr) awv <= 0;
      if (wr_r) wv <= 0;
      if (bv) begin
        brd <= 0;
        chk("bresp", e, br);
      end
    end while (awv || wv || brd);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] er);
    ara <= a;
    arv <= 1;
    rrd <= 1;
    do begin
      @(posedge sys_clk);
      if (arr) arv <= 0;
      if (rv) begin
        rrd <= 0;
        chk("rdata", e, rdat);
        chk("rresp", er, rr);
      end
    end while (arv || rrd);
  endtask
  task automatic ep1(logic [7:0] e);
    tok <= 1;
    tick(1);
    tok <= 0;
    tick(1);
    chk("ep1", {e == 0, e != 0, e}, {nak, snd, e == 0 ? e : ep_d});
  endtask
  task automatic eof;
    eof2 <= 1;
    tick(1);
    eof2 <= 0;
    tick(1);
  endtask
  task automatic s_reset;
    chk("power", 0, pwr);
    chk("led", 4'hF, ind);
    rd(`HPM_A_CTRL, 0, 0);
    rd(8'h40, 0, 2);
  endtask
  task automatic s_unconf;
    wr(`HPM_A_CMD, 32'hF, 0);
    tick(4);
    chk("power", 0, pwr);
    ep1(0);
  endtask
  task automatic s_power;
    wr(`HPM_A_CTRL, 32'hF, 0);
    rd(`HPM_A_CTRL, 32'hF, 0);
    wr(`HPM_A_CTRL, 1, 0);
    wr(`HPM_A_CMD, 32'hF, 0);
    wr(`HPM_A_CMD, 32'hF00, 0);
    tick(2);
    chk("power", 4'hF, pwr);
    chk("led", 0, ind);
    wr(`HPM_A_CMD, 32'h2000, 0);
    tick(2);
    chk("led", 4'h2, ind);
  endtask
  task automatic s_oc;
    int n;
    logic prev;
    wr(`HPM_A_IMASK, 32'h1F, 0);
    fault <= 4'h4;
    tick(5);
    chk("power", 4'hB, pwr);
    rd(`HPM_A_PSTAT, 32'h4449B, 0);
    chk("irq", 1, irq);
    n = 0;
    prev = ind[2];
    repeat (20) begin
      @(posedge sys_clk);
      if (ind[2] !== prev) n++;
      prev = ind[2];
    end
    chk("blink", 1, n >= 2);
    eof;
    ep1(8'h08);
    wr(`HPM_A_ISTAT, 32'h1F, 0);
    chk("irq", 0, irq);
    fault <= 0;
    wr(`HPM_A_CMD, 32'h40, 0);
    tick(3);
    chk("led", 4'h6, ind);
    wr(`HPM_A_CMD, 32'h40000, 0);
    eof;
    ep1(0);
    wr(`HPM_A_CMD, 32'h80, 0);
    chk("power", 4'h3, pwr);
    fault <= 4'h1;
    tick(5);
    chk("power", 4'h2, pwr);
    chk("irq", 1, irq);
    hubc <= 1;
    eof;
    ep1(8'h03);
    hubc <= 0;
    fault <= 0;
    wr(`HPM_A_CMD, 32'h100000, 0);
    rd(`HPM_A_PSTAT, 32'h1002, 0);
    wr(`HPM_A_CTRL, 0, 0);
    chk("power", 0, pwr);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      finish_test;
    end
  end
  initial begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    {arst_n, awv, wv, brd, arv, rrd, eof2, hubc, tok} = 0;
    {awa, ara, wd, fault} = 0;
    tick(3);
    arst_n <= 1;
    tick(1);
    s_reset;
    s_unconf;
    s_power;
    s_oc;
    finish_test;
  end
endmodule // tb
`default_nettype wire
